/* File: rtl/wdat_pkg.sv */
package wdat_pkg;
    // ****************************************
    // Register map seen by the core
    // ****************************************
    localparam logic [7:0] WD_CONTROL_ONE_ADDR = 8'h34;
    localparam logic [7:0] WD_CODE_REGISTER_ADDR = 8'h35;
    localparam int OVERFLOW_ACTION_SELECT_POS = 0;
    localparam int DETECTION_TIME_SELECT_POS = 1;
    localparam int WD_ENABLE_BIT_POS = 3;
    localparam int TRAP_ACTION_SELECT_POS = 4;
    localparam int RAM_TRAP_SELECT_POS = 5;
    localparam logic [7:0] WD_CONTROL_ONE_RESET = 8'h39;
    localparam logic [7:0] CODE_CLEAR = 8'h4E;
    localparam logic [7:0] CODE_DISABLE = 8'hB1;
    localparam logic [7:0] CODE_TRAP_ENABLE = 8'hD2;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10000000;
    localparam int RESET_MAX_FC_PERIODS = 24;
    localparam int RESET_REF_FC_HZ = 16000000;
    localparam int RESET_PULSE_NS = RESET_MAX_FC_PERIODS * 1000 /
        (RESET_REF_FC_HZ / 1000000);
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS * (CLK_HZ / 1000000) / 1000) < 1 ? 1 :
        (RESET_PULSE_NS * (CLK_HZ / 1000000) / 1000);
    // ****************************************
    // Controller APB map
    // ****************************************
    localparam logic [7:0] APB_CMD_ADDR = 8'h00;
    localparam logic [7:0] APB_STATUS_ADDR = 8'h04;
    localparam logic [7:0] APB_FETCH_ADDR = 8'h08;
    localparam int CMD_WRITE_POS = 8;
    localparam int CMD_ADDR_POS = 16;
    localparam logic [31:0] APB_ERROR_DATA = 32'hDEADBEEF;
endpackage : wdat_pkg

/* File: rtl/wdat_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface wdat_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic fetch_valid;
    logic [15:0] fetch_addr;
    logic mode_pause;
    logic slow_single_clock_mode;
    logic wd_overflow_irq;
    logic fetch_trap_irq;
    logic reset_req;
    logic enabled;
    modport device (
        input wr_en, wr_addr, wr_data, fetch_valid, fetch_addr,
        input mode_pause, slow_single_clock_mode,
        output wd_overflow_irq, fetch_trap_irq, reset_req, enabled
    );
    modport core (
        output wr_en, wr_addr, wr_data, fetch_valid, fetch_addr,
        output mode_pause, slow_single_clock_mode,
        input wd_overflow_irq, fetch_trap_irq, reset_req, enabled
    );
endinterface : wdat_if
`default_nettype wire

/* File: rtl/wdat_watchdog.sv */
// Contract
// - Enable resets to one; writing one enables
// - Stop: mask, clear code, enable zero, disable
// - Disabled watchdog holds binary counter cleared
// - Select zero: overflow raises interrupt request
// - Watchdog interrupt is non-maskable
// - New watchdog interrupt preempts one in service
// - Software sets stack before interrupt output
// - Select one: overflow resets, bounded pulse
// - Slow-mode reset still timed on fast clock
// - RAM trap select applies after D2H
// - RAM fetch traps only when select one
// - SPECIAL_FUNCTION_AREA and debug fetches always trap
// - Trap action zero raises trap interrupt
// - Trap interrupt is non-maskable
// - New trap interrupt preempts one in service
// - Software sets stack before trap interrupts
// - Trap action one resets, bounded pulse
// - Clear code clears counter, not divider
// - Overflow select one-shot once cleared
// - Disable code accepted only when enable zero; here the code has no effect, only clearing enable bit 3 disables
// - Pause counting in stop, idle, sleep
`timescale 1ns/1ns
`default_nettype none
module wdat_watchdog #(
    parameter int DIV_WIDTH = 8,
    parameter logic [15:0] SFR_LAST = 16'h003F,
    parameter logic [15:0] RAM_FIRST = 16'h0040,
    parameter logic [15:0] RAM_LAST = 16'h083F,
    parameter logic [15:0] DBR_FIRST = 16'h0F80,
    parameter logic [15:0] DBR_LAST = 16'h0FFF
) (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, low
    input wire logic clk_en_i, // Freezes all state when low
    wdat_if.device bus // Core side
);
    // ****************************************
    // Checks and helpers
    // ****************************************
    initial begin
        if (DIV_WIDTH < 4 || DIV_WIDTH > 24) begin
            $error("DIV_WIDTH out of range");
        end
    end

    function automatic logic in_range(input logic [15:0] a,
            input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    logic [7:0] ctrl_q;
    logic ram_trap_active_q;
    logic [DIV_WIDTH+3:0] div_q;
    logic [1:0] bin_q;
    logic [7:0] rst_cnt_q;
    logic wd_irq_q;
    logic trap_irq_q;
    logic pending_ovf_q;
    logic pending_trap_q;

    wire logic wr1 = clk_en_i && bus.wr_en
        && bus.wr_addr == wdat_pkg::WD_CONTROL_ONE_ADDR;
    wire logic wr2 = clk_en_i && bus.wr_en
        && bus.wr_addr == wdat_pkg::WD_CODE_REGISTER_ADDR;
    wire logic enable = ctrl_q[wdat_pkg::WD_ENABLE_BIT_POS];
    wire logic ovf_sel = ctrl_q[wdat_pkg::OVERFLOW_ACTION_SELECT_POS];
    wire logic trap_sel = ctrl_q[wdat_pkg::TRAP_ACTION_SELECT_POS];
    wire logic [1:0] dts = ctrl_q[wdat_pkg::DETECTION_TIME_SELECT_POS +: 2];
    wire logic counting = enable && !bus.mode_pause;
    // Detection time selects which divider tap clocks the binary counter
    wire logic [DIV_WIDTH+3:0] div_n = div_q + 1'b1;
    wire logic tap_now = div_q[DIV_WIDTH + 3 - int'(dts)];
    wire logic tap_nxt = div_n[DIV_WIDTH + 3 - int'(dts)];
    wire logic tick = counting && !tap_now && tap_nxt;
    wire logic overflow = tick && bin_q == 2'b11;
    wire logic fetch_hit = bus.fetch_valid && clk_en_i && (
        in_range(bus.fetch_addr, 16'h0000, SFR_LAST) ||
        in_range(bus.fetch_addr, DBR_FIRST, DBR_LAST) ||
        (ram_trap_active_q
         && in_range(bus.fetch_addr, RAM_FIRST, RAM_LAST)));
    wire logic ovf_event = clk_en_i && overflow;

    // ****************************************
    // Control register one
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= wdat_pkg::WD_CONTROL_ONE_RESET;
        end else if (wr1) begin
            ctrl_q <= bus.wr_data;
            // Once cleared, overflow select cannot come back
            if (!ovf_sel) begin
                ctrl_q[wdat_pkg::OVERFLOW_ACTION_SELECT_POS] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ram_trap_active_q <= 1'b1;
        end else if (wr2 && bus.wr_data == wdat_pkg::CODE_TRAP_ENABLE) begin
            ram_trap_active_q <= ctrl_q[wdat_pkg::RAM_TRAP_SELECT_POS];
        end
    end

    // ****************************************
    // Divider and binary counter
    // ****************************************
    // Divider is never cleared by software, so first period may be short
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= '0;
        end else if (clk_en_i && counting) begin
            div_q <= div_n;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bin_q <= 2'b00;
        end else if (clk_en_i) begin
            if (!enable) begin
                bin_q <= 2'b00;
            end else if (wr2 && bus.wr_data == wdat_pkg::CODE_CLEAR) begin
                bin_q <= 2'b00;
            end else if (tick) begin
                bin_q <= bin_q + 2'b01;
            end
        end
    end

    // Disable code is matched only while enable is already zero, but that branch
    // and the one for other codes both just hold pending_ovf_q at zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_ovf_q <= 1'b0;
        end else if (wr2 && bus.wr_data == wdat_pkg::CODE_DISABLE
                && !enable) begin
            pending_ovf_q <= 1'b0;
        end else begin
            pending_ovf_q <= 1'b0;
        end
    end

    // ****************************************
    // Event outputs
    // ****************************************
    // Each request is a one-cycle pulse; the core treats it as an NMI,
    // so a new pulse preempts whatever it is servicing
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_irq_q <= 1'b0;
            trap_irq_q <= 1'b0;
        end else if (clk_en_i) begin
            wd_irq_q <= ovf_event && !ovf_sel;
            trap_irq_q <= fetch_hit && !trap_sel;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_trap_q <= 1'b0;
        end else begin
            pending_trap_q <= 1'b0;
        end
    end

    // Reset pulse counted on mclk, which keeps running in slow mode too
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_cnt_q <= 8'h00;
        end else if (!clk_en_i) begin
            // Frozen with the rest of the state
            rst_cnt_q <= rst_cnt_q;
        end else if ((ovf_event && ovf_sel)
                || (fetch_hit && trap_sel)) begin
            rst_cnt_q <= 8'(wdat_pkg::RESET_PULSE_CYCLES);
        end else if (rst_cnt_q != 8'h00) begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
        end
    end

    assign bus.wd_overflow_irq = wd_irq_q;
    assign bus.fetch_trap_irq = trap_irq_q;
    assign bus.reset_req = rst_cnt_q != 8'h00;
    assign bus.enabled = enable;
endmodule : wdat_watchdog
`default_nettype wire

/* File: rtl/wdat_core_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module wdat_core_ctrl (
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, low
    input wire logic clk_en_i, // Freezes all state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    wdat_if.core bus // Watchdog side
);
    logic wr_en_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic fetch_valid_q;
    logic [15:0] fetch_addr_q;
    logic [1:0] modes_q;
    logic [3:0] sticky_q;
    logic [31:0] prdata_q;

    wire logic acc = psel && penable && clk_en_i;
    wire logic wr = acc && pwrite;
    wire logic hit = paddr == wdat_pkg::APB_CMD_ADDR
        || paddr == wdat_pkg::APB_STATUS_ADDR
        || paddr == wdat_pkg::APB_FETCH_ADDR;

    // ****************************************
    // Command issue: one write strobe per APB command write with bit 8 set, stack set-up
    // and the stop order are software's duty
    // ****************************************
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_en_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            fetch_valid_q <= 1'b0;
            fetch_addr_q <= 16'h0000;
            modes_q <= 2'b00;
        end else if (clk_en_i) begin
            wr_en_q <= wr && paddr == wdat_pkg::APB_CMD_ADDR
                && pwdata[wdat_pkg::CMD_WRITE_POS];
            fetch_valid_q <= wr && paddr == wdat_pkg::APB_FETCH_ADDR;
            if (wr && paddr == wdat_pkg::APB_CMD_ADDR) begin
                wr_data_q <= pwdata[7:0];
                wr_addr_q <= pwdata[wdat_pkg::CMD_ADDR_POS +: 8];
                modes_q <= pwdata[10:9];
            end
            if (wr && paddr == wdat_pkg::APB_FETCH_ADDR) begin
                fetch_addr_q <= pwdata[15:0];
            end
        end
    end

    // Sticky events; set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sticky_q <= 4'h0;
        end else if (clk_en_i) begin
            sticky_q <= (sticky_q & ~((wr && paddr ==
                wdat_pkg::APB_STATUS_ADDR) ? pwdata[3:0] : 4'h0))
                | {bus.reset_req, bus.fetch_trap_irq, bus.wd_overflow_irq,
                   1'b0};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h00000000;
        end else if (clk_en_i && psel && !penable && !pwrite) begin
            case (paddr)
                wdat_pkg::APB_STATUS_ADDR:
                    prdata_q <= {27'h0, bus.enabled, sticky_q};
                wdat_pkg::APB_CMD_ADDR:
                    prdata_q <= {21'h0, modes_q, 1'b0, wr_data_q};
                wdat_pkg::APB_FETCH_ADDR:
                    prdata_q <= {16'h0, fetch_addr_q};
                default:
                    prdata_q <= wdat_pkg::APB_ERROR_DATA;
            endcase
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_q;
    assign bus.wr_en = wr_en_q;
    assign bus.wr_addr = wr_addr_q;
    assign bus.wr_data = wr_data_q;
    assign bus.fetch_valid = fetch_valid_q;
    assign bus.fetch_addr = fetch_addr_q;
    assign bus.mode_pause = modes_q[0];
    assign bus.slow_single_clock_mode = modes_q[1];
endmodule : wdat_core_ctrl
`default_nettype wire

/* File: tb/wdat_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module wdat_properties (
    input wire logic mclk_i, // Clock
    input wire logic rst_n_i, // Async reset, low
    input wire logic wr_en, // Core write strobe
    input wire logic [7:0] wr_addr, // Core write address
    input wire logic [7:0] wr_data, // Core write data
    input wire logic fetch_valid, // Fetch strobe
    input wire logic [15:0] fetch_addr, // Fetch address
    input wire logic mode_pause, // Low-power pause
    input wire logic slow_single_clock_mode, // Slow clock mode
    input wire logic wd_overflow_irq, // Overflow request
    input wire logic fetch_trap_irq, // Trap request
    input wire logic reset_req, // Reset request
    input wire logic enabled // Enable bit
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ****
    // Steps
    // ****
    logic [7:0] rst_high_q;
    // Counts cycles the reset request has stood; too long to unroll
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_high_q <= 8'h00;
        end else if (reset_req) begin
            rst_high_q <= rst_high_q + 8'h01;
        end else begin
            rst_high_q <= 8'h00;
        end
    end
    sequence s_reset_end;
        $fell(reset_req);
    endsequence
    sequence s_sys_fetch;
        fetch_valid && (fetch_addr <= 16'h003F ||
            (fetch_addr >= 16'h0F80 && fetch_addr <= 16'h0FFF));
    endsequence
    // ****
    // Checks
    // ****
    chk_wd_pulse: assert property (
        wd_overflow_irq |=> !wd_overflow_irq)
        else $error("overflow request longer than one cycle");
    chk_trap_pulse: assert property (
        fetch_trap_irq |=> !fetch_trap_irq)
        else $error("trap request longer than one cycle");
    chk_sys_trap: assert property (
        s_sys_fetch |=> (fetch_trap_irq || reset_req))
        else $error("system area fetch not trapped");
    chk_trap_cause: assert property (
        fetch_trap_irq |-> $past(fetch_valid))
        else $error("trap request without a fetch");
    chk_reset_len: assert property (
        s_reset_end |->
        rst_high_q == 8'(wdat_pkg::RESET_PULSE_CYCLES))
        else $error("reset request width wrong");
    chk_enable_cause: assert property (
        $fell(enabled) |-> $past(wr_en && wr_addr == 8'h34 && !wr_data[3]))
        else $error("enable dropped without a write");
    chk_disabled_quiet: assert property (
        !enabled && $past(!enabled) |-> !wd_overflow_irq)
        else $error("overflow while disabled");
    chk_pause_hold: assert property (
        mode_pause && $past(mode_pause) && $past(mode_pause, 2)
        |-> !wd_overflow_irq)
        else $error("overflow while paused");
endmodule : wdat_properties
`default_nettype wire

/* File: tb/watchdog_with_address_trap_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module watchdog_with_address_trap_bench;
    localparam logic [7:0] CTL = wdat_pkg::WD_CONTROL_ONE_ADDR;
    localparam logic [7:0] COD = wdat_pkg::WD_CODE_REGISTER_ADDR;
    localparam logic [7:0] STA = wdat_pkg::APB_STATUS_ADDR;
    localparam logic [7:0] CMD = wdat_pkg::APB_CMD_ADDR;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic er;
    int n_errors = 0;
    int tests_run = 0;
    wdat_if bus_if();
    wdat_watchdog #(.DIV_WIDTH(4)) wdat_watchdog_i (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .clk_en_i(1'b1), .bus(bus_if.device));
    wdat_core_ctrl wdat_core_ctrl_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .clk_en_i(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus_if.core));
    wdat_properties wdat_properties_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .wr_en(bus_if.wr_en), .wr_addr(bus_if.wr_addr),
        .wr_data(bus_if.wr_data), .fetch_valid(bus_if.fetch_valid),
        .fetch_addr(bus_if.fetch_addr), .mode_pause(bus_if.mode_pause),
        .slow_single_clock_mode(bus_if.slow_single_clock_mode),
        .wd_overflow_irq(bus_if.wd_overflow_irq),
        .fetch_trap_irq(bus_if.fetch_trap_irq),
        .reset_req(bus_if.reset_req), .enabled(bus_if.enabled));
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // ****
    // Tasks
    // ****
    task automatic stop_test;
        $display("Checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Request held until the edge where pready is seen; data taken there
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic core_wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, CMD, {8'h00, a, 8'h01, d});
    endtask : core_wr
    task automatic fetch(input logic [15:0] a);
        apb(1'b1, wdat_pkg::APB_FETCH_ADDR, {16'h0000, a});
        // Let a reset request run out before its sticky bit is cleared
        repeat (wdat_pkg::RESET_PULSE_CYCLES + 8) @(posedge mclk_i);
    endtask : fetch
    // Bits: enabled, reset seen, trap seen, overflow seen; then cleared
    task automatic stat(input string nm, input logic [3:0] exp);
        apb(1'b0, STA, 32'h00000000);
        chk(nm, {28'h0000000, exp}, {28'h0000000, rd[4:1]});
        apb(1'b1, STA, 32'h0000000E);
    endtask : stat
    // ****
    // Tests
    // ****
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        core_wr(COD, wdat_pkg::CODE_CLEAR);
        stat("after_reset", 4'h8);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk("unmapped_err", 32'h00000001, {31'h00000000, er});
        chk("unmapped_data", wdat_pkg::APB_ERROR_DATA, rd);
        fetch(16'h0010);
        stat("sfr_reset", 4'hC);
        core_wr(CTL, 8'h28);
        fetch(16'h0F80);
        stat("dbr_irq", 4'hA);
        core_wr(COD, wdat_pkg::CODE_CLEAR);
        core_wr(CTL, 8'h08);
        fetch(16'h0040);
        stat("ram_before_code", 4'hA);
        core_wr(COD, wdat_pkg::CODE_TRAP_ENABLE);
        fetch(16'h0040);
        stat("ram_no_trap", 4'h8);
        fetch(16'h0FFF);
        stat("dbr_last", 4'hA);
        core_wr(COD, wdat_pkg::CODE_DISABLE);
        core_wr(COD, 8'h55);
        stat("disable_refused", 4'h8);
        core_wr(COD, wdat_pkg::CODE_CLEAR);
        core_wr(CTL, 8'h06);
        core_wr(COD, wdat_pkg::CODE_DISABLE);
        repeat (2000) @(posedge mclk_i);
        stat("disabled_idle", 4'h0);
        // Pause lands one cycle before enable; output select tries to return
        apb(1'b1, CMD, {8'h00, CTL, 8'h03, 8'h0F});
        repeat (2000) @(posedge mclk_i);
        stat("paused_hold", 4'h8);
        apb(1'b1, CMD, 32'h00000000);
        repeat (3000) begin
            apb(1'b0, STA, 32'h00000000);
            if (rd[1] === 1'b1) break;
        end
        stat("overflow_irq", 4'h9);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        n_errors++;
        stop_test();
    end
endmodule : watchdog_with_address_trap_bench
`default_nettype wire
